//--- rtl/opfs_top.sv
// Contract
// - pin 3: gpio, reserved, timer B, pulse seven
// - pin 2: gpio, reserved, timer A, pulse six
// - pin 1: gpio, fast clock, pulse five, reserved
// - pin 0: gpio, slow clock, pulse four, reserved
// - function registers: bits 3-0 RW, 7-4 zero
// - function registers reset to zero, gpio mode
// - output only, no direction, no input
// - per-pin hiz, P-open, N-open or CMOS drive
// - reset leaves every pin high impedance
// - gpio mode drives the data register bit
// - drive codes: hiz, P-open, N-open, CMOS
// - data register four RW bits, resets zero
`timescale 1ns/10ps
`default_nettype none
`include "opfs_consts.svh"

module opfs_top (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [`OPFS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`OPFS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic slow_clock_out,
  input wire logic fast_clock_out,
  input wire logic timer_a_out,
  input wire logic timer_b_out,
  input wire logic pulse_channel_four,
  input wire logic pulse_channel_five,
  input wire logic pulse_channel_six,
  input wire logic pulse_channel_seven,
  output logic out_pin_0,
  output logic out_pin_0_oe,
  output logic out_pin_1,
  output logic out_pin_1_oe,
  output logic out_pin_2,
  output logic out_pin_2_oe,
  output logic out_pin_3,
  output logic out_pin_3_oe
);

  typedef struct packed {
    logic [3:0] output_port_data;
    logic [3:0] drive_mode_select_low;
    logic [3:0] drive_mode_select_high;
    logic [3:0] pin_function_select_low;
    logic [3:0] pin_function_select_high;
    logic [3:0] pin_level;
    logic [3:0] pin_oe;
  } opfs_state_s;

  opfs_state_s st_ff;
  opfs_state_s nxt_st;
  logic wr_en;
  opfs_pkg::opfs_reg_e wr_sel;
  logic [3:0] wr_data;
  opfs_pkg::opfs_reg_e rd_sel;
  logic [31:0] rd_data;
  logic [7:0] periph;

  assign periph = {pulse_channel_seven, pulse_channel_six, pulse_channel_five,
                   pulse_channel_four, timer_b_out, timer_a_out, fast_clock_out,
                   slow_clock_out};

  opfs_axil_slave u_bus (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_sel(wr_sel),
    .wr_data(wr_data),
    .rd_sel(rd_sel),
    .rd_data(rd_data)
  );

  // Picks the level a pin should carry from its function code.
  // periph: {pulse seven..four, timer b, timer a, fast clock, slow clock}
  function automatic logic route(input logic [1:0] pin, input logic [1:0] code,
                                 input logic gpio, input logic [7:0] src);
    logic val;
    val = gpio;
    case (pin)
      2'h0:
      begin
        if (code == `OPFS_FUNC_ONE)
          val = src[0];
        else if (code == `OPFS_FUNC_TWO)
          val = src[4];
      end
      2'h1:
      begin
        if (code == `OPFS_FUNC_ONE)
          val = src[1];
        else if (code == `OPFS_FUNC_TWO)
          val = src[5];
      end
      2'h2:
      begin
        if (code == `OPFS_FUNC_TWO)
          val = src[2];
        else if (code == `OPFS_FUNC_THREE)
          val = src[6];
      end
      default:
      begin
        if (code == `OPFS_FUNC_TWO)
          val = src[3];
        else if (code == `OPFS_FUNC_THREE)
          val = src[7];
      end
    endcase
    return val;
  endfunction

  // Returns {level, enable}; open-drain modes only ever drive one rail
  function automatic logic [1:0] drive(input logic [1:0] mode, input logic val);
    logic [1:0] res;
    case (mode)
      `OPFS_DRV_POD:
        res = {1'b1, val};
      `OPFS_DRV_NOD:
        res = {1'b0, !val};
      `OPFS_DRV_CMOS:
        res = {val, 1'b1};
      default:
        res = 2'h0;
    endcase
    return res;
  endfunction

  always_comb
  begin
    case (rd_sel)
      opfs_pkg::OPFS_REG_DATA:
        rd_data = {28'h0, st_ff.output_port_data};
      opfs_pkg::OPFS_REG_DRV_LOW:
        rd_data = {28'h0, st_ff.drive_mode_select_low};
      opfs_pkg::OPFS_REG_DRV_HIGH:
        rd_data = {28'h0, st_ff.drive_mode_select_high};
      opfs_pkg::OPFS_REG_FUNC_LOW:
        rd_data = {28'h0, st_ff.pin_function_select_low};
      opfs_pkg::OPFS_REG_FUNC_HIGH:
        rd_data = {28'h0, st_ff.pin_function_select_high};
      default:
        rd_data = 32'h0;
    endcase
  end

  always_comb
  begin
    logic [1:0] lvl_oe;
    lvl_oe = 2'h0;
    nxt_st = st_ff;
    if (wr_en)
    begin
      case (wr_sel)
        opfs_pkg::OPFS_REG_DATA:
          nxt_st.output_port_data = wr_data;
        opfs_pkg::OPFS_REG_DRV_LOW:
          nxt_st.drive_mode_select_low = wr_data;
        opfs_pkg::OPFS_REG_DRV_HIGH:
          nxt_st.drive_mode_select_high = wr_data;
        opfs_pkg::OPFS_REG_FUNC_LOW:
          nxt_st.pin_function_select_low = wr_data;
        opfs_pkg::OPFS_REG_FUNC_HIGH:
          nxt_st.pin_function_select_high = wr_data;
        default:
          nxt_st.output_port_data = st_ff.output_port_data;
      endcase
    end
    // Pins follow the registers one cycle late so every pin output is a flop.
    // gpio drives the data bit
    for (int i = 0; i < `OPFS_PIN_N; i++)
    begin
      lvl_oe = drive({st_ff.drive_mode_select_high[i], st_ff.drive_mode_select_low[i]},
                     route(2'(i), {st_ff.pin_function_select_high[i],
                                   st_ff.pin_function_select_low[i]},
                           st_ff.output_port_data[i], periph));
      nxt_st.pin_level[i] = lvl_oe[1];
      nxt_st.pin_oe[i] = lvl_oe[0];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign out_pin_0 = st_ff.pin_level[0];
  assign out_pin_0_oe = st_ff.pin_oe[0];
  assign out_pin_1 = st_ff.pin_level[1];
  assign out_pin_1_oe = st_ff.pin_oe[1];
  assign out_pin_2 = st_ff.pin_level[2];
  assign out_pin_2_oe = st_ff.pin_oe[2];
  assign out_pin_3 = st_ff.pin_level[3];
  assign out_pin_3_oe = st_ff.pin_oe[3];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_func_write;
    wr_en && (wr_sel == opfs_pkg::OPFS_REG_FUNC_LOW);
  endsequence

  sequence s_data_write;
    wr_en && (wr_sel == opfs_pkg::OPFS_REG_DATA);
  endsequence

  a_pin3_timer_b: assert property (
    (st_ff.pin_function_select_high[3] && !st_ff.pin_function_select_low[3]
     && st_ff.drive_mode_select_high[3] && st_ff.drive_mode_select_low[3])
    |=> (out_pin_3 == $past(timer_b_out)) && out_pin_3_oe)
    else $error("pin 3 does not carry timer B");

  a_pin2_pulse_six: assert property (
    (st_ff.pin_function_select_high[2] && st_ff.pin_function_select_low[2]
     && st_ff.drive_mode_select_high[2] && st_ff.drive_mode_select_low[2])
    |=> out_pin_2 == $past(pulse_channel_six))
    else $error("pin 2 does not carry pulse six");

  a_pin1_fast_clock: assert property (
    (!st_ff.pin_function_select_high[1] && st_ff.pin_function_select_low[1]
     && st_ff.drive_mode_select_high[1] && st_ff.drive_mode_select_low[1])
    |=> out_pin_1 == $past(fast_clock_out))
    else $error("pin 1 does not carry the fast clock");

  a_pin0_pulse_four: assert property (
    (st_ff.pin_function_select_high[0] && !st_ff.pin_function_select_low[0]
     && st_ff.drive_mode_select_high[0] && st_ff.drive_mode_select_low[0])
    |=> out_pin_0 == $past(pulse_channel_four))
    else $error("pin 0 does not carry pulse four");

  a_func_write_mask: assert property (
    s_func_write |=> st_ff.pin_function_select_low == $past(wr_data))
    else $error("function register write lost");

  a_read_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0)
    else $error("read data upper bits not zero");

  a_hiz_no_drive: assert property (
    (!st_ff.drive_mode_select_high[0] && !st_ff.drive_mode_select_low[0])
    |=> !out_pin_0_oe)
    else $error("pin 0 driven in high impedance mode");

  a_gpio_level: assert property (
    (st_ff.pin_function_select_high[2:0] == 3'h0 && st_ff.pin_function_select_low[2:0] == 3'h0
     && st_ff.drive_mode_select_high[1] && st_ff.drive_mode_select_low[1])
    |=> out_pin_1 == $past(st_ff.output_port_data[1]))
    else $error("gpio pin 1 does not follow the data bit");

  a_nod_low_only: assert property (
    (st_ff.drive_mode_select_high[2] && !st_ff.drive_mode_select_low[2])
    |=> !out_pin_2)
    else $error("N-open drain pin drove high");

  a_data_readback: assert property (
    s_data_write |=> st_ff.output_port_data == $past(wr_data))
    else $error("data register did not take the write");

  a_reserved_gpio: assert property (
    (!st_ff.pin_function_select_high[3] && st_ff.pin_function_select_low[3]
     && st_ff.drive_mode_select_high[3] && st_ff.drive_mode_select_low[3])
    |=> out_pin_3 == $past(st_ff.output_port_data[3]))
    else $error("reserved code on pin 3 not treated as gpio");

endmodule

`default_nettype wire

//--- rtl/opfs_consts.svh
`ifndef OPFS_CONSTS_SVH
`define OPFS_CONSTS_SVH

// Register indexes; the byte address is four times the index
`define OPFS_IDX_DATA 16'hF228
`define OPFS_IDX_DRV_LOW 16'hF22A
`define OPFS_IDX_DRV_HIGH 16'hF22B
`define OPFS_IDX_FUNC_LOW 16'hF22C
`define OPFS_IDX_FUNC_HIGH 16'hF22D

`define OPFS_ADDR_W 20
`define OPFS_PIN_N 4
`define OPFS_REG_RESET 4'h0

// Function codes, {msb, lsb}
`define OPFS_FUNC_GPIO 2'h0
`define OPFS_FUNC_ONE 2'h1
`define OPFS_FUNC_TWO 2'h2
`define OPFS_FUNC_THREE 2'h3

// Drive codes, {high-register bit, low-register bit}
`define OPFS_DRV_HIZ 2'h0
`define OPFS_DRV_POD 2'h1
`define OPFS_DRV_NOD 2'h2
`define OPFS_DRV_CMOS 2'h3

`define OPFS_RESP_OKAY 2'h0
`define OPFS_RESP_SLVERR 2'h2

`endif

//--- rtl/opfs_pkg.sv
`include "opfs_consts.svh"

package opfs_pkg;

  typedef enum logic [2:0] {
    OPFS_REG_NONE,
    OPFS_REG_DATA,
    OPFS_REG_DRV_LOW,
    OPFS_REG_DRV_HIGH,
    OPFS_REG_FUNC_LOW,
    OPFS_REG_FUNC_HIGH
  } opfs_reg_e;

  // Used for both the write and the read address
  function automatic opfs_reg_e decode(input logic [`OPFS_ADDR_W-1:0] addr);
    opfs_reg_e sel;
    sel = OPFS_REG_NONE;
    if (addr == {2'h0, `OPFS_IDX_DATA, 2'h0})
      sel = OPFS_REG_DATA;
    else if (addr == {2'h0, `OPFS_IDX_DRV_LOW, 2'h0})
      sel = OPFS_REG_DRV_LOW;
    else if (addr == {2'h0, `OPFS_IDX_DRV_HIGH, 2'h0})
      sel = OPFS_REG_DRV_HIGH;
    else if (addr == {2'h0, `OPFS_IDX_FUNC_LOW, 2'h0})
      sel = OPFS_REG_FUNC_LOW;
    else if (addr == {2'h0, `OPFS_IDX_FUNC_HIGH, 2'h0})
      sel = OPFS_REG_FUNC_HIGH;
    return sel;
  endfunction

endpackage

//--- rtl/opfs_axil_slave.sv
`timescale 1ns/10ps
`default_nettype none
`include "opfs_consts.svh"

module opfs_axil_slave (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [`OPFS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`OPFS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output opfs_pkg::opfs_reg_e wr_sel,
  output logic [3:0] wr_data,
  output opfs_pkg::opfs_reg_e rd_sel,
  input wire logic [31:0] rd_data
);

  typedef struct packed {
    logic aw_held;
    logic w_held;
    logic [`OPFS_ADDR_W-1:0] waddr;
    logic [3:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } opfs_axi_s;

  opfs_axi_s st_ff;
  opfs_axi_s nxt_st;
  logic do_write;

  assign s_axi_awready = !st_ff.aw_held && !st_ff.bvalid;
  assign s_axi_wready = !st_ff.w_held && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rresp = st_ff.rresp;
  assign s_axi_rdata = st_ff.rdata;
  assign wr_sel = opfs_pkg::decode(st_ff.waddr);
  assign rd_sel = opfs_pkg::decode(s_axi_araddr);
  assign do_write = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
  // Only the low byte lane carries register bits
  assign wr_en = do_write && st_ff.wstrb0 && (wr_sel != opfs_pkg::OPFS_REG_NONE);
  assign wr_data = st_ff.wdata;

  always_comb
  begin
    nxt_st = st_ff;
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_st.aw_held = 1'b1;
      nxt_st.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_st.w_held = 1'b1;
      nxt_st.wdata = s_axi_wdata[3:0];
      nxt_st.wstrb0 = s_axi_wstrb[0];
    end
    if (do_write)
    begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = (wr_sel == opfs_pkg::OPFS_REG_NONE) ? `OPFS_RESP_SLVERR : `OPFS_RESP_OKAY;
    end
    if (st_ff.bvalid && s_axi_bready)
      nxt_st.bvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd_data;
      nxt_st.rresp = (rd_sel == opfs_pkg::OPFS_REG_NONE) ? `OPFS_RESP_SLVERR : `OPFS_RESP_OKAY;
    end
    if (st_ff.rvalid && s_axi_rready)
      nxt_st.rvalid = 1'b0;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

endmodule

`default_nettype wire

//--- tb/opfs_pin_load.sv
`timescale 1ns/10ps
`default_nettype none

module opfs_pin_load (
  input wire logic [3:0] level,
  input wire logic [3:0] oe,
  output logic [3:0] pin_wire
);
  // LEDs hang from the supply, so a released pin is pulled high
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      pin_wire[i] = oe[i] ? level[i] : 1'b1;
    end
  end
endmodule

`default_nettype wire

//--- tb/test_output_port_function_select.sv
`timescale 1ns/10ps
`default_nettype none
`include "opfs_consts.svh"

module test_output_port_function_select;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [19:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [19:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [7:0] periph = '0;
  logic slow_clock_out, fast_clock_out, timer_a_out, timer_b_out;
  logic pulse_channel_four, pulse_channel_five, pulse_channel_six, pulse_channel_seven;
  logic out_pin_0, out_pin_1, out_pin_2, out_pin_3;
  logic out_pin_0_oe, out_pin_1_oe, out_pin_2_oe, out_pin_3_oe;
  logic [3:0] po;
  logic [3:0] pin_wire;
  logic [3:0] strb = 4'hF;
  logic [15:0] regs [5] = '{`OPFS_IDX_DATA, `OPFS_IDX_DRV_LOW, `OPFS_IDX_DRV_HIGH,
    `OPFS_IDX_FUNC_LOW, `OPFS_IDX_FUNC_HIGH};
  // Source bit per pin and function code, -1 routes the data bit
  int src [4][4] = '{'{-1, 0, 4, -1}, '{-1, 1, 5, -1}, '{-1, -1, 2, 6}, '{-1, -1, 3, 7}};
  int mismatches = 0;
  int samples_checked = 0;

  assign {pulse_channel_seven, pulse_channel_six, pulse_channel_five, pulse_channel_four,
    timer_b_out, timer_a_out, fast_clock_out, slow_clock_out} = periph;
  assign po = {out_pin_3_oe, out_pin_2_oe, out_pin_1_oe, out_pin_0_oe};

  always #25 core_clk = ~core_clk;

  opfs_top opfs_top_i (
    .core_clk(core_clk), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .slow_clock_out(slow_clock_out), .fast_clock_out(fast_clock_out),
    .timer_a_out(timer_a_out), .timer_b_out(timer_b_out),
    .pulse_channel_four(pulse_channel_four), .pulse_channel_five(pulse_channel_five),
    .pulse_channel_six(pulse_channel_six), .pulse_channel_seven(pulse_channel_seven),
    .out_pin_0(out_pin_0), .out_pin_0_oe(out_pin_0_oe),
    .out_pin_1(out_pin_1), .out_pin_1_oe(out_pin_1_oe),
    .out_pin_2(out_pin_2), .out_pin_2_oe(out_pin_2_oe),
    .out_pin_3(out_pin_3), .out_pin_3_oe(out_pin_3_oe)
  );

  opfs_pin_load opfs_pin_load_i (
    .level({out_pin_3, out_pin_2, out_pin_1, out_pin_0}),
    .oe(po),
    .pin_wire(pin_wire)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  function automatic logic [19:0] ad(input logic [15:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  task automatic wr(input logic [19:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] rs;
    tb = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= strb;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb)
    begin
      // Ready is settled mid-cycle, so sampling here avoids an edge race
      @(negedge core_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid === 1'b1;
      rs = s_axi_bresp;
      @(posedge core_clk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk(32'(rs), 32'(er));
  endtask

  task automatic rd(input logic [19:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic tr, ta;
    logic [31:0] dat;
    logic [1:0] rs;
    tr = 1'b0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr)
    begin
      @(negedge core_clk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid === 1'b1;
      dat = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge core_clk);
      if (ta)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(dat, ed);
    chk(32'(rs), 32'(er));
  endtask

  task automatic settle;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  initial
  begin
    logic [3:0] dp;
    logic [3:0] eoe;
    logic [3:0] ew;
    logic [7:0] pv;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    settle();
    chk(32'(po), 32'h0);
    foreach (regs[i])
      rd(ad(regs[i]), 32'h0, `OPFS_RESP_OKAY);
    $display("test reset done");
    for (int j = 0; j < 2; j++)
    begin
      foreach (regs[i])
      begin
        wr(ad(regs[i]), j ? 32'h0000_005A : 32'hFFFF_FFA5, `OPFS_RESP_OKAY);
        rd(ad(regs[i]), j ? 32'h0000_000A : 32'h0000_0005, `OPFS_RESP_OKAY);
      end
    end
    wr(ad(16'hF229), 32'h1, `OPFS_RESP_SLVERR);
    rd(ad(16'hF229), 32'h0, `OPFS_RESP_SLVERR);
    // A write without the low byte lane must leave the register alone
    strb = 4'hE;
    wr(ad(`OPFS_IDX_DATA), 32'h5, `OPFS_RESP_OKAY);
    strb = 4'hF;
    rd(ad(`OPFS_IDX_DATA), 32'hA, `OPFS_RESP_OKAY);
    wr(ad(`OPFS_IDX_FUNC_LOW), 32'h0, `OPFS_RESP_OKAY);
    wr(ad(`OPFS_IDX_FUNC_HIGH), 32'h0, `OPFS_RESP_OKAY);
    $display("test registers done");
    for (int c = 0; c < 4; c++)
    begin
      for (int j = 0; j < 2; j++)
      begin
        dp = j ? 4'hA : 4'h5;
        wr(ad(`OPFS_IDX_DRV_LOW), {28'h0, {4{c[0]}}}, `OPFS_RESP_OKAY);
        wr(ad(`OPFS_IDX_DRV_HIGH), {28'h0, {4{c[1]}}}, `OPFS_RESP_OKAY);
        wr(ad(`OPFS_IDX_DATA), {28'h0, dp}, `OPFS_RESP_OKAY);
        settle();
        eoe = (c == 0) ? 4'h0 : (c == 1) ? dp : (c == 2) ? ~dp : 4'hF;
        ew = (c < 2) ? 4'hF : dp;
        chk(32'(po), 32'(eoe));
        chk(32'(pin_wire), 32'(ew));
      end
    end
    $display("test drive done");
    wr(ad(`OPFS_IDX_DRV_LOW), 32'hF, `OPFS_RESP_OKAY);
    wr(ad(`OPFS_IDX_DRV_HIGH), 32'hF, `OPFS_RESP_OKAY);
    wr(ad(`OPFS_IDX_DATA), 32'hF, `OPFS_RESP_OKAY);
    for (int c = 0; c < 4; c++)
    begin
      wr(ad(`OPFS_IDX_FUNC_LOW), {28'h0, {4{c[0]}}}, `OPFS_RESP_OKAY);
      wr(ad(`OPFS_IDX_FUNC_HIGH), {28'h0, {4{c[1]}}}, `OPFS_RESP_OKAY);
      for (int k = 0; k < 9; k++)
      begin
        pv = (k < 8) ? 8'h01 << k : 8'h00;
        @(posedge core_clk);
        periph <= pv;
        settle();
        for (int i = 0; i < 4; i++)
          ew[i] = (src[i][c] < 0) ? 1'b1 : pv[src[i][c]];
        chk(32'(pin_wire), 32'(ew));
      end
    end
    $display("test functions done");
    @(posedge core_clk);
    reset_n <= 1'b0;
    settle();
    chk(32'(po), 32'h0);
    @(posedge core_clk);
    reset_n <= 1'b1;
    rd(ad(`OPFS_IDX_FUNC_HIGH), 32'h0, `OPFS_RESP_OKAY);
    $display("test second reset done");
    print_verdict();
  end

  initial
  begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    print_verdict();
  end
endmodule

`default_nettype wire
